/* core/sim_regs.vh */
// Register map, field positions and timing constants of the system integrity monitor
`ifndef SIM_REGS_VH
`define SIM_REGS_VH

// Control/status register byte address
`define SIM_ADDR_CTRL_STATUS 4'h0

// Field positions in the control/status register
`define SIM_BIT_SRC_SEL 7
`define SIM_BIT_VIRQ_EN 6
`define SIM_BIT_VLOW_FLAG 5
`define SIM_BIT_LVRST_FLAG 4
`define SIM_BIT_RSVD 3
`define SIM_BIT_CGIRQ_EN 2
`define SIM_BIT_SAFE_FLAG 1
`define SIM_BIT_WDRST_FLAG 0

// Reset value of the register, cause bits excluded
`define SIM_CTRL_RESET 8'h00

// Reset delay after a low-supply, watchdog or external reset, in CPU cycles
`define SIM_DELAY_SHORT 13'h0100
`define SIM_DELAY_LONG 13'h1000

// AXI4-Lite responses
`define SIM_RESP_OKAY 2'h0
`define SIM_RESP_SLVERR 2'h2

`endif

/* core/sim_sync.v */
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ns
`default_nettype none

module sim_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  input wire ce,
  // Data
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] meta_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {W{1'b0}};
      q <= {W{1'b0}};
    end else if (ce) begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule // sim_sync

`default_nettype wire

/* core/sim_clk_guard.v */
// Clock guard: safe oscillator switchover, glitch filter enable and safe-oscillator-active flag
`timescale 1ns/1ns
`default_nettype none

module sim_clk_guard (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  input wire ce,
  // Options and modes
  input wire opt_guard_en,
  input wire opt_doubler_en,
  input wire halt_mode,
  // Synchronised main clock loss
  input wire osc_lost_s,
  // Register read of the control/status register
  input wire reg_read,
  // Outputs
  output reg safe_sel_q,
  output reg safe_osc_en_q,
  output reg filter_en_q,
  output reg safe_flag_q
);

  wire guard_on;
  wire safe_d;

  // Halt disables the switchover and the safe oscillator; the glitch filter enable does not depend on halt
  assign guard_on = opt_guard_en & ~halt_mode;
  assign safe_d = guard_on & osc_lost_s;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      safe_sel_q <= 1'b0;
      safe_osc_en_q <= 1'b0;
      filter_en_q <= 1'b0;
      safe_flag_q <= 1'b0;
    end else if (ce) begin
      safe_sel_q <= safe_d;
      safe_osc_en_q <= guard_on;
      filter_en_q <= opt_guard_en & opt_doubler_en;
      if (!opt_guard_en) begin
        safe_flag_q <= 1'b0;
      end else if (halt_mode) begin
        safe_flag_q <= safe_flag_q;
      end else if (safe_d) begin
        // Set wins over a read in the same cycle
        safe_flag_q <= 1'b1;
      end else if (reg_read) begin
        safe_flag_q <= 1'b0;
      end
    end
  end

endmodule // sim_clk_guard

`default_nettype wire

/* core/sim_top.v */
// System integrity monitor: low-supply reset, auxiliary voltage detector, clock guard, AXI4-Lite register
// Operation
// - Hold chip in static reset while supply is below the detector threshold.
// - Release above upper threshold, assert below lower threshold: hysteresis.
// - Drive external reset pin low during a low-supply reset.
// - No low-supply reset unless the option enables the detector.
// - Voltage-low flag mirrors the auxiliary comparator live and is read-only.
// - Auxiliary detector, flag and interrupt work only with detector option on.
// - Bit 7 picks supply (0) or external pin (1); software owned.
// - With enable set, both comparator edges request a voltage interrupt.
// - No voltage interrupt for crossings inside the post-reset delay.
// - Enabling while flag shows low raises one interrupt at enable time.
// - Pending voltage interrupt clears on service entry; enable is bit 6.
// - Glitch filter works only when the frequency doubler is on.
// - Lost main clock switches the core to the safe oscillator.
// - Core returns to the main oscillator once it recovers.
// - Safe-oscillator flag set in hardware; interrupt if its enable is set.
// - Interrupts reach the CPU only when enabled and CPU mask clear.
// - Wait mode changes nothing; enabled events wake the device.
// - Halt freezes the register and disables the clock guard.
// - After reset the register reads zero except cause bits 4 and 0.
// - Bit 5 reads 0 above upper, 1 below lower threshold; hardware only.
// - Safe flag bit 1 clears on register read after recovery; enable bit 2.
// - Bit 4 set by low-supply reset, cleared only by writing zero.
// - Bit 0 set by watchdog reset, cleared by writing zero or low-supply reset.
`timescale 1ns/1ns
`default_nettype none
`include "sim_regs.vh"

module sim_top #(
  parameter AW = 4
) (
  // Clock, reset, enable
  input wire clk,
  input wire rst_n,
  input wire ce,
  // Option settings
  input wire opt_lvd_en,
  input wire opt_long_delay,
  input wire opt_guard_en,
  input wire opt_doubler_en,
  // Analog comparators, asynchronous, high when voltage is below threshold
  input wire lvd_below_upper,
  input wire lvd_below_lower,
  input wire aux_supply_low,
  input wire aux_pin_low,
  // Main oscillator monitor, asynchronous, high when clock has vanished
  input wire main_osc_lost,
  // Reset causes and CPU status
  input wire wdg_reset_evt,
  input wire ext_reset_evt,
  input wire cpu_irq_masked,
  input wire voltage_isr_enter,
  input wire wait_mode,
  input wire halt_mode,
  // AXI4-Lite write address
  input wire [AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Reset outputs, reset pin is open drain
  output reg sys_reset_q,
  output reg reset_pin_out,
  output reg reset_pin_oe,
  // Clock control
  output wire safe_clk_sel,
  output wire safe_osc_en,
  output wire glitch_filter_en,
  // Interrupts and wake-up
  output reg voltage_irq,
  output reg clock_guard_irq,
  output reg wait_wake
);

  // Synchronised analog inputs
  wire [4:0] async_in;
  wire [4:0] sync_out;
  wire below_upper_s;
  wire below_lower_s;
  wire sup_low_s;
  wire pin_low_s;
  wire osc_lost_s;

  assign async_in = {main_osc_lost, aux_pin_low, aux_supply_low, lvd_below_lower, lvd_below_upper};

  sim_sync #(
    .W(5)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d(async_in),
    .q(sync_out)
  );

  assign below_upper_s = sync_out[0];
  assign below_lower_s = sync_out[1];
  assign sup_low_s = sync_out[2];
  assign pin_low_s = sync_out[3];
  assign osc_lost_s = sync_out[4];

  // Register fields
  reg src_sel_q;
  reg virq_en_q;
  reg vlow_flag_q;
  reg lvrst_flag_q;
  reg cgirq_en_q;
  reg wdrst_flag_q;
  reg vpend_q;
  wire safe_flag;

  // Low-supply detector state and post-reset delay
  reg low_q;
  reg [12:0] delay_cnt_q;
  wire low_d;
  wire delay_busy;
  wire [12:0] delay_len;

  // Bus state
  reg aw_held_q;
  reg w_held_q;
  reg [AW-1:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire aw_fire;
  wire w_fire;
  wire wr_go;
  wire [AW-1:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire ar_fire;
  wire wr_hit;
  wire rd_hit;
  wire reg_wr;
  wire reg_rd;
  wire [7:0] reg_rdata;

  // Reset value as a vector so that single control bits can be picked from it
  localparam [7:0] CTRL_RST = `SIM_CTRL_RESET;

  function addr_hit;
    input [AW-1:0] a;
    begin
      addr_hit = (a[AW-1:2] == `SIM_ADDR_CTRL_STATUS >> 2);
    end
  endfunction

  // Hysteresis: once low, release needs the upper threshold; running, reset needs the lower
  assign low_d = opt_lvd_en & (low_q ? below_upper_s : below_lower_s);

  assign delay_len = opt_long_delay ? `SIM_DELAY_LONG : `SIM_DELAY_SHORT;
  assign delay_busy = (delay_cnt_q != 13'h0000);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_q <= 1'b0;
      sys_reset_q <= 1'b0;
      reset_pin_out <= 1'b0;
      reset_pin_oe <= 1'b0;
      delay_cnt_q <= 13'h0000;
    end else if (ce) begin
      low_q <= low_d;
      sys_reset_q <= low_d;
      reset_pin_out <= 1'b0;
      reset_pin_oe <= low_d;
      // Reload while in reset so the delay counts from the release
      if (low_d | wdg_reset_evt | ext_reset_evt) begin
        delay_cnt_q <= delay_len;
      end else if (delay_busy) begin
        delay_cnt_q <= delay_cnt_q - 13'h0001;
      end
    end
  end

  // AXI4-Lite write path: address and data are taken in either order
  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire = s_axi_wvalid & s_axi_wready;
  assign wr_go = (aw_held_q | aw_fire) & (w_held_q | w_fire) & ~s_axi_bvalid;
  assign wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  assign wr_data = w_held_q ? wdata_q : s_axi_wdata;
  assign wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
  assign wr_hit = addr_hit(wr_addr);
  // Halt freezes the register, so software writes are dropped then
  assign reg_wr = wr_go & wr_hit & wr_strb[0] & ~halt_mode;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SIM_RESP_OKAY;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= {AW{1'b0}};
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else if (ce) begin
      if (aw_fire) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_fire) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `SIM_RESP_OKAY : `SIM_RESP_SLVERR;
      end else begin
        aw_held_q <= aw_held_q | aw_fire;
        w_held_q <= w_held_q | w_fire;
        if (s_axi_bvalid & s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
      s_axi_awready <= ~s_axi_awready & ~aw_held_q & ~aw_fire & ~s_axi_bvalid & ~wr_go;
      s_axi_wready <= ~s_axi_wready & ~w_held_q & ~w_fire & ~s_axi_bvalid & ~wr_go;
    end
  end

  // AXI4-Lite read path, one cycle from address to data
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign rd_hit = addr_hit(s_axi_araddr);
  assign reg_rd = ar_fire & rd_hit;

  assign reg_rdata = {src_sel_q, virq_en_q, vlow_flag_q, lvrst_flag_q, 1'b0, cgirq_en_q, safe_flag, wdrst_flag_q};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SIM_RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & ~ar_fire;
      if (ar_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_hit ? {24'h000000, reg_rdata} : 32'h00000000;
        s_axi_rresp <= rd_hit ? `SIM_RESP_OKAY : `SIM_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Clock guard
  sim_clk_guard u_guard (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .opt_guard_en(opt_guard_en),
    .opt_doubler_en(opt_doubler_en),
    .halt_mode(halt_mode),
    .osc_lost_s(osc_lost_s),
    .reg_read(reg_rd),
    .safe_sel_q(safe_clk_sel),
    .safe_osc_en_q(safe_osc_en),
    .filter_en_q(glitch_filter_en),
    .safe_flag_q(safe_flag)
  );

  // Auxiliary voltage detector
  wire aux_now;
  wire aux_edge;
  wire virq_rise;
  wire vpend_set;
  wire chip_reset;

  assign aux_now = opt_lvd_en & (src_sel_q ? pin_low_s : sup_low_s);
  // Edges during the reset delay are absorbed silently
  assign aux_edge = (aux_now != vlow_flag_q) & ~delay_busy & ~low_q;
  assign virq_rise = reg_wr & wr_data[`SIM_BIT_VIRQ_EN] & ~virq_en_q;
  assign vpend_set = opt_lvd_en & ~halt_mode & ((aux_edge & virq_en_q) | (virq_rise & vlow_flag_q));
  assign chip_reset = low_q | wdg_reset_evt | ext_reset_evt;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_sel_q <= 1'b0;
      virq_en_q <= 1'b0;
      cgirq_en_q <= 1'b0;
      vlow_flag_q <= 1'b0;
      lvrst_flag_q <= 1'b0;
      wdrst_flag_q <= 1'b0;
      vpend_q <= 1'b0;
    end else if (ce) begin
      if (!halt_mode) begin
        vlow_flag_q <= aux_now;
      end
      if (chip_reset) begin
        // Any reset returns the control bits to their reset value
        src_sel_q <= CTRL_RST[`SIM_BIT_SRC_SEL];
        virq_en_q <= CTRL_RST[`SIM_BIT_VIRQ_EN];
        cgirq_en_q <= CTRL_RST[`SIM_BIT_CGIRQ_EN];
        vpend_q <= 1'b0;
      end else begin
        if (reg_wr) begin
          src_sel_q <= wr_data[`SIM_BIT_SRC_SEL];
          virq_en_q <= wr_data[`SIM_BIT_VIRQ_EN];
          cgirq_en_q <= wr_data[`SIM_BIT_CGIRQ_EN];
        end
        // Set wins over the service-entry clear
        if (vpend_set) begin
          vpend_q <= 1'b1;
        end else if (voltage_isr_enter) begin
          vpend_q <= 1'b0;
        end
      end
      // Bit 4 survives the other chip resets, bit 0 all but a low-supply reset; writing one leaves them alone
      if (low_q) begin
        lvrst_flag_q <= 1'b1;
      end else if (reg_wr & ~wr_data[`SIM_BIT_LVRST_FLAG]) begin
        lvrst_flag_q <= 1'b0;
      end
      if (low_q) begin
        wdrst_flag_q <= 1'b0;
      end else if (wdg_reset_evt) begin
        wdrst_flag_q <= 1'b1;
      end else if (reg_wr & ~wr_data[`SIM_BIT_WDRST_FLAG]) begin
        wdrst_flag_q <= 1'b0;
      end
    end
  end

  // Interrupt requests to the CPU and wake-up from wait
  wire v_req;
  wire cg_req;

  assign v_req = vpend_q & virq_en_q;
  // Clock guard enable has no effect when the guard is not fitted
  assign cg_req = safe_flag & cgirq_en_q & opt_guard_en;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      voltage_irq <= 1'b0;
      clock_guard_irq <= 1'b0;
      wait_wake <= 1'b0;
    end else if (ce) begin
      voltage_irq <= v_req & ~cpu_irq_masked;
      clock_guard_irq <= cg_req & ~cpu_irq_masked;
      // Neither source may leave halt, only wait
      wait_wake <= wait_mode & ~halt_mode & (v_req | cg_req);
    end
  end

endmodule // sim_top

`default_nettype wire

/* verification/sim_top_properties.sv */
// Port-level assertions for the system integrity monitor
`timescale 1ns/1ns
`default_nettype none
`include "sim_regs.vh"

module sim_top_properties #(
  parameter AW = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Options, comparators, CPU status
  input wire logic opt_lvd_en,
  input wire logic opt_guard_en,
  input wire logic opt_doubler_en,
  input wire logic lvd_below_upper,
  input wire logic lvd_below_lower,
  input wire logic main_osc_lost,
  input wire logic cpu_irq_masked,
  input wire logic voltage_isr_enter,
  input wire logic wait_mode,
  input wire logic halt_mode,
  // Read channel
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // Reset, clock control, interrupts
  input wire logic sys_reset_q,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic safe_clk_sel,
  input wire logic safe_osc_en,
  input wire logic glitch_filter_en,
  input wire logic voltage_irq,
  input wire logic clock_guard_irq,
  input wire logic wait_wake
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Async inputs pass two sync stages and an output flop, so four samples settle them
  sequence rd_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[3:2] != 2'h0;
  endsequence
  sequence rd_error;
    s_axi_rvalid && s_axi_rresp == `SIM_RESP_SLVERR && s_axi_rdata == 32'h0;
  endsequence

  a_lvd_hold: assert property ((opt_lvd_en && lvd_below_lower) [*4] |-> sys_reset_q)
    else $error("low-supply reset not held");
  a_lvd_release: assert property ((!opt_lvd_en || !lvd_below_upper) [*4] |-> !sys_reset_q)
    else $error("low-supply reset not released");
  a_pin_drive: assert property (reset_pin_oe == sys_reset_q && !reset_pin_out)
    else $error("reset pin does not follow reset");
  a_irq_mask: assert property (cpu_irq_masked [*2] |-> !voltage_irq && !clock_guard_irq)
    else $error("interrupt passed the mask");
  a_isr_clear: assert property (voltage_isr_enter |-> ##2 !voltage_irq)
    else $error("voltage interrupt not cleared on service");
  a_guard_switch: assert property ((opt_guard_en && !halt_mode && main_osc_lost) [*4] |-> safe_clk_sel)
    else $error("no switch to safe oscillator");
  a_guard_back: assert property ((!main_osc_lost) [*4] |-> !safe_clk_sel)
    else $error("no return to main oscillator");
  a_halt_guard: assert property (halt_mode [*2] |-> !safe_clk_sel && !safe_osc_en)
    else $error("clock guard active in halt");
  a_filter_gate: assert property ((!opt_doubler_en) [*3] |-> !glitch_filter_en)
    else $error("glitch filter on without doubler");
  a_wait_wake: assert property (wait_mode && (voltage_irq || clock_guard_irq) |-> ##[0:2] wait_wake)
    else $error("no wake from wait");
  a_read_unmapped: assert property (rd_unmapped |=> rd_error)
    else $error("unmapped read not refused");
endmodule // sim_top_properties

bind sim_top sim_top_properties #(.AW(AW)) u_props (
  .clk(clk), .rst_n(rst_n), .opt_lvd_en(opt_lvd_en), .opt_guard_en(opt_guard_en), .opt_doubler_en(opt_doubler_en),
  .lvd_below_upper(lvd_below_upper), .lvd_below_lower(lvd_below_lower), .main_osc_lost(main_osc_lost),
  .cpu_irq_masked(cpu_irq_masked), .voltage_isr_enter(voltage_isr_enter),
  .wait_mode(wait_mode), .halt_mode(halt_mode),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .sys_reset_q(sys_reset_q), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
  .safe_clk_sel(safe_clk_sel), .safe_osc_en(safe_osc_en), .glitch_filter_en(glitch_filter_en),
  .voltage_irq(voltage_irq), .clock_guard_irq(clock_guard_irq), .wait_wake(wait_wake)
);

`default_nettype wire

/* verification/sim_top_test.sv */
// Self-checking bench for the system integrity monitor
`timescale 1ns/1ns
`default_nettype none
`include "sim_regs.vh"

module sim_top_test;
  typedef struct {logic [3:0] a; logic [7:0] d; logic [3:0] s; logic [7:0] e;} sim_row_t;
  logic clk = 1'b0;
  logic rst_n, ce, opt_lvd_en, opt_long_delay, opt_guard_en, opt_doubler_en;
  logic lvd_below_upper, lvd_below_lower, aux_supply_low, aux_pin_low, main_osc_lost;
  logic wdg_reset_evt, ext_reset_evt, cpu_irq_masked, voltage_isr_enter, wait_mode, halt_mode;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic sys_reset_q, reset_pin_out, reset_pin_oe, safe_clk_sel, safe_osc_en, glitch_filter_en;
  wire logic voltage_irq, clock_guard_irq, wait_wake;
  int err_total = 0;
  int n_checks = 0;
  logic [1:0] rsp, er;
  logic [31:0] rv;
  // Only bits 7, 6 and 2 take written ones; a cleared strobe byte or an unmapped address changes nothing
  sim_row_t rows [7] = '{'{4'h0, 8'hff, 4'hf, 8'hc4}, '{4'h0, 8'h3b, 4'hf, 8'h00}, '{4'h0, 8'h84, 4'he, 8'h00},
    '{4'h0, 8'h80, 4'h1, 8'h80}, '{4'h4, 8'hff, 4'hf, 8'h00}, '{4'h8, 8'h41, 4'hf, 8'h00}, '{4'hc, 8'h04, 4'hf, 8'h00}};

  sim_top dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .opt_lvd_en(opt_lvd_en), .opt_long_delay(opt_long_delay),
    .opt_guard_en(opt_guard_en), .opt_doubler_en(opt_doubler_en),
    .lvd_below_upper(lvd_below_upper), .lvd_below_lower(lvd_below_lower),
    .aux_supply_low(aux_supply_low), .aux_pin_low(aux_pin_low), .main_osc_lost(main_osc_lost),
    .wdg_reset_evt(wdg_reset_evt), .ext_reset_evt(ext_reset_evt), .cpu_irq_masked(cpu_irq_masked),
    .voltage_isr_enter(voltage_isr_enter), .wait_mode(wait_mode), .halt_mode(halt_mode),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .sys_reset_q(sys_reset_q), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
    .safe_clk_sel(safe_clk_sel), .safe_osc_en(safe_osc_en), .glitch_filter_en(glitch_filter_en),
    .voltage_irq(voltage_irq), .clock_guard_irq(clock_guard_irq), .wait_wake(wait_wake)
  );

  always #20 clk = ~clk;

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic test_done;
    if (err_total == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic limit(input int k);
    if (k >= 40) begin
      err_total++;
      test_done;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
    int k = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && k < 40);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    limit(k);
  endtask

  task automatic rd(input logic [3:0] a);
    int k = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && k < 40);
    rv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    limit(k);
  endtask

  task automatic rdc(input logic [7:0] e);
    rd(4'h0);
    chk("ctrl_status", {24'h0, e}, rv);
  endtask

  task automatic vi(input logic e);
    step(5);
    chk("voltage_irq", e, voltage_irq);
  endtask

  task automatic isr;
    voltage_isr_enter <= 1'b1;
    step(1);
    voltage_isr_enter <= 1'b0;
    step(3);
    chk("voltage_irq", 0, voltage_irq);
  endtask

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    opt_lvd_en = 1'b1;
    {opt_long_delay, opt_guard_en, opt_doubler_en, lvd_below_upper, lvd_below_lower} = '0;
    {aux_supply_low, aux_pin_low, main_osc_lost, wdg_reset_evt, ext_reset_evt} = '0;
    {cpu_irq_masked, voltage_isr_enter, wait_mode, halt_mode} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
    step(10);
    rst_n <= 1'b1;
    step(1);
    rdc(8'h00);
    // The power-on reset starts no delay; a chip reset does
    ext_reset_evt <= 1'b1;
    step(1);
    ext_reset_evt <= 1'b0;
    wr(4'h0, 8'h40, 4'hf);
    aux_supply_low <= 1'b1;
    vi(1'b0);
    aux_supply_low <= 1'b0;
    vi(1'b0);
    foreach (rows[i]) begin
      er = rows[i].a[3:2] != 2'h0 ? `SIM_RESP_SLVERR : `SIM_RESP_OKAY;
      wr(rows[i].a, rows[i].d, rows[i].s);
      chk("bresp", er, rsp);
      rd(rows[i].a);
      chk("rdata", {24'h0, rows[i].e}, rv);
      chk("rresp", er, rsp);
    end
    rdc(8'h80);
    // Let the 256-cycle post-reset delay run out before counting edges
    step(300);
    wr(4'h0, 8'h40, 4'hf);
    aux_supply_low <= 1'b1;
    vi(1'b1);
    rdc(8'h60);
    isr;
    cpu_irq_masked <= 1'b1;
    aux_supply_low <= 1'b0;
    vi(1'b0);
    cpu_irq_masked <= 1'b0;
    wait_mode <= 1'b1;
    vi(1'b1);
    chk("wait_wake", 1, wait_wake);
    wait_mode <= 1'b0;
    isr;
    wr(4'h0, 8'hc0, 4'hf);
    aux_supply_low <= 1'b1;
    vi(1'b0);
    aux_pin_low <= 1'b1;
    vi(1'b1);
    rdc(8'he0);
    isr;
    aux_pin_low <= 1'b0;
    vi(1'b1);
    isr;
    wr(4'h0, 8'h00, 4'hf);
    vi(1'b0);
    wr(4'h0, 8'h40, 4'hf);
    vi(1'b1);
    isr;
    aux_supply_low <= 1'b0;
    vi(1'b1);
    isr;
    opt_lvd_en <= 1'b0;
    aux_supply_low <= 1'b1;
    vi(1'b0);
    aux_supply_low <= 1'b0;
    step(5);
    opt_lvd_en <= 1'b1;
    wr(4'h0, 8'h00, 4'hf);
    wdg_reset_evt <= 1'b1;
    step(1);
    wdg_reset_evt <= 1'b0;
    rdc(8'h01);
    opt_lvd_en <= 1'b0;
    lvd_below_upper <= 1'b1;
    lvd_below_lower <= 1'b1;
    step(6);
    chk("sys_reset_q", 0, sys_reset_q);
    opt_lvd_en <= 1'b1;
    step(5);
    chk("sys_reset_q", 1, sys_reset_q);
    chk("reset_pin_oe", 1, reset_pin_oe);
    lvd_below_lower <= 1'b0;
    step(5);
    chk("sys_reset_q", 1, sys_reset_q);
    lvd_below_upper <= 1'b0;
    step(5);
    chk("sys_reset_q", 0, sys_reset_q);
    rdc(8'h10);
    ext_reset_evt <= 1'b1;
    step(1);
    ext_reset_evt <= 1'b0;
    rdc(8'h10);
    wr(4'h0, 8'h00, 4'hf);
    rdc(8'h00);
    lvd_below_upper <= 1'b1;
    step(5);
    chk("sys_reset_q", 0, sys_reset_q);
    lvd_below_upper <= 1'b0;
    main_osc_lost <= 1'b1;
    step(5);
    chk("safe_clk_sel", 0, safe_clk_sel);
    opt_guard_en <= 1'b1;
    step(5);
    chk("safe_clk_sel", 1, safe_clk_sel);
    wr(4'h0, 8'h04, 4'hf);
    step(2);
    chk("clock_guard_irq", 1, clock_guard_irq);
    cpu_irq_masked <= 1'b1;
    step(2);
    chk("clock_guard_irq", 0, clock_guard_irq);
    cpu_irq_masked <= 1'b0;
    rdc(8'h06);
    rdc(8'h06);
    main_osc_lost <= 1'b0;
    step(5);
    chk("safe_clk_sel", 0, safe_clk_sel);
    rdc(8'h06);
    rdc(8'h04);
    opt_doubler_en <= 1'b1;
    step(3);
    chk("glitch_filter_en", 1, glitch_filter_en);
    halt_mode <= 1'b1;
    step(3);
    chk("safe_osc_en", 0, safe_osc_en);
    wr(4'h0, 8'h00, 4'hf);
    halt_mode <= 1'b0;
    step(3);
    rdc(8'h04);
    opt_doubler_en <= 1'b0;
    step(3);
    chk("glitch_filter_en", 0, glitch_filter_en);
    // Long delay: an edge after 300 cycles is still absorbed, one after 4096 is not
    opt_long_delay <= 1'b1;
    ext_reset_evt <= 1'b1;
    step(1);
    ext_reset_evt <= 1'b0;
    wr(4'h0, 8'h40, 4'hf);
    step(300);
    aux_supply_low <= 1'b1;
    vi(1'b0);
    step(4000);
    aux_supply_low <= 1'b0;
    vi(1'b1);
    isr;
    opt_long_delay <= 1'b0;
    rst_n <= 1'b0;
    step(3);
    rst_n <= 1'b1;
    step(1);
    rdc(8'h00);
    test_done;
  end
endmodule // sim_top_test

`default_nettype wire
